// ==== hdl/gpio_port_defines.svh ====
// Offsets, widths, reset values and codes of the five-pin port
`ifndef GPIO_PORT_DEFINES_SVH
`define GPIO_PORT_DEFINES_SVH

// ============================================================
// Register indices (byte addresses are four times these)
`define PIN_DATA_IDX 16'hf26e
`define PIN_DIRECTION_IDX 16'hf26f
`define DRIVE_CONFIG_LOW_IDX 16'hf270
`define DRIVE_CONFIG_HIGH_IDX 16'hf271
`define FUNCTION_SELECT_LOW_IDX 16'hf272
`define FUNCTION_SELECT_HIGH_IDX 16'hf273

// ============================================================
// Widths and reset values
`define PIN_COUNT 5
`define REG_WIDTH 8
`define REG_RESET 8'h00

// ============================================================
// Drive configuration codes {high bit, low bit}
`define DRIVE_HIZ 2'h0
`define DRIVE_PCH_OD 2'h1
`define DRIVE_NCH_OD 2'h2
`define DRIVE_CMOS 2'h3

// ============================================================
// Function select codes {high bit, low bit}
`define FUNC_PORT 2'h0
`define FUNC_SECONDARY 2'h1
`define FUNC_TERTIARY 2'h2
`define FUNC_QUARTIC 2'h3

`endif

// ==== hdl/gpio_port_pkg.sv ====
// Types shared by the five-pin port files
package gpio_port_pkg;

    // ============================================================
    // APB request from the bus
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    // ============================================================
    // Per-pin drive state handed to the pad driver
    typedef struct packed {
        logic [4:0] out;
        logic [4:0] oe_n;
        logic [4:0] pull_up;
        logic [4:0] pull_down;
    } pad_drive_type;

    // Bus answer state
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DONE = 2'b10
    } bus_state_type;

endpackage

// ==== hdl/pin_driver.sv ====
// Per-pin drive resolution of the five-pin port
`timescale 1ns/100ps
`include "gpio_port_defines.svh"
module pin_driver
    import gpio_port_pkg::*;
#(
    parameter int PINS = `PIN_COUNT
)
(
    // Configuration
    input wire logic [PINS-1:0] dir,
    input wire logic [PINS-1:0] data,
    input wire logic [PINS-1:0] cfg_lo,
    input wire logic [PINS-1:0] cfg_hi,
    input wire logic [PINS-1:0] func_lo,
    input wire logic [PINS-1:0] func_hi,
    // Alternate function sources
    input wire logic pwm_out_a,
    input wire logic pwm_out_b,
    input wire logic uart_a_tx,
    input wire logic uart_b_tx,
    input wire logic serial_clock_out,
    input wire logic serial_clock_oe,
    input wire logic serial_data_out,
    // Resolved drive
    output wire pad_drive_type drive
);

    // ============================================================
    // Function availability per pin and code
    function automatic logic func_valid(input int pin, input logic [1:0] f);
        logic ok;
        ok = (f == `FUNC_PORT);
        case (pin)
            0, 1: ok = ok | (f == `FUNC_TERTIARY);
            2: ok = ok | (f == `FUNC_SECONDARY) | (f == `FUNC_TERTIARY);
            3: ok = 1'b1;
            4: ok = ok | (f == `FUNC_TERTIARY);
            default: ok = ok;
        endcase
        return ok;
    endfunction

    // ============================================================
    // Alternate output sources; input-only functions yield none
    wire logic [PINS-1:0] alt_val;
    wire logic [PINS-1:0] alt_drives;
    assign alt_val[0] = pwm_out_a;
    assign alt_val[1] = pwm_out_b;
    assign alt_val[2] = 1'b0;
    assign alt_val[3] = (func_hi[3] & func_lo[3]) ? uart_a_tx :
                        func_hi[3] ? serial_clock_out : uart_b_tx;
    assign alt_val[4] = serial_data_out;
    // Pin 2 carries inputs only; the serial clock may turn round
    assign alt_drives[0] = 1'b1;
    assign alt_drives[1] = 1'b1;
    assign alt_drives[2] = 1'b0;
    assign alt_drives[3] = !(func_hi[3] & !func_lo[3]) | serial_clock_oe;
    assign alt_drives[4] = 1'b1;

    // ============================================================
    // Per-pin resolution
    genvar i;
    generate
        for (i = 0; i < PINS; i++)
        begin : g_pin
            wire logic [1:0] cfg = {cfg_hi[i], cfg_lo[i]};
            wire logic [1:0] fn = {func_hi[i], func_lo[i]};
            wire logic bad = !func_valid(i, fn);
            wire logic is_port = (fn == `FUNC_PORT);
            // Unassigned function forces low; alternate replaces data
            wire logic val = bad ? 1'b0 :
                             is_port ? data[i] : alt_val[i];
            wire logic out_mode = !dir[i] & (is_port | bad | alt_drives[i]);
            // Open drain drives only the level it can pull
            wire logic en = out_mode &
                ((cfg == `DRIVE_CMOS) |
                 (cfg == `DRIVE_PCH_OD && val) |
                 (cfg == `DRIVE_NCH_OD && !val));
            assign drive.out[i] = val;
            assign drive.oe_n[i] = !en;
            assign drive.pull_down[i] = dir[i] & (cfg == `DRIVE_PCH_OD);
            assign drive.pull_up[i] = dir[i] & (cfg == `DRIVE_NCH_OD);
        end
    endgenerate

endmodule

// ==== hdl/gpio_port.sv ====
// Five-pin general-purpose port with APB register access
// ============================================================
// Behaviour
// - A direction bit of 0 makes its pin an output, 1 an input.
// - An output pin is driven to the level held in the data register.
// - Reading the data register gives the pin level for input pins.
// - Written data bits are kept and read back for output pins.
// - Output drive codes: 00 float, 01 P open drain, 10 N open drain, 11 push-pull.
// - Input codes: 00 float, 01 pull-down, 10 pull-up, 11 float.
// - Reset clears every register, leaving floating outputs on port function.
// - Five pins sit on bits 4 down to 0 of each register.
// - Pins 0,1 carry PWM, pins 2 to 4 UART and serial, pin 3 a second UART transmit.
// - Two select bits pick port, secondary, tertiary or quartic function.
// - An unassigned function ignores data: floats or holds low by drive type.
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps
`include "gpio_port_defines.svh"
module gpio_port
    import gpio_port_pkg::*;
#(
    parameter int PINS = `PIN_COUNT
)
(
    // Clock, reset and enable
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pads
    input wire logic [PINS-1:0] pin_in,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe_n,
    output logic [PINS-1:0] pin_pull_up,
    output logic [PINS-1:0] pin_pull_down,
    // Alternate function sources
    input wire logic pwm_out_a,
    input wire logic pwm_out_b,
    input wire logic uart_a_tx,
    input wire logic uart_b_tx,
    input wire logic serial_clock_out,
    input wire logic serial_clock_oe,
    input wire logic serial_data_out,
    // Alternate function returns to the peripherals
    output logic uart_b_rx,
    output logic serial_data_in,
    output logic serial_clock_in
);

    // ============================================================
    // Register state
    logic [PINS-1:0] data_q;
    logic [PINS-1:0] dir_q;
    logic [PINS-1:0] cfg_lo_q;
    logic [PINS-1:0] cfg_hi_q;
    logic [PINS-1:0] func_lo_q;
    logic [PINS-1:0] func_hi_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [PINS-1:0] pin_out_q;
    logic [PINS-1:0] pin_oe_n_q;
    logic [PINS-1:0] pull_up_q;
    logic [PINS-1:0] pull_down_q;
    logic uart_b_rx_q;
    logic serial_data_in_q;
    logic serial_clock_in_q;
    bus_state_type bus_q;
    bus_state_type bus_d;
    apb_req_type req;
    pad_drive_type drive;

    // ============================================================
    // Address decode helpers
    function automatic logic hit(input logic [31:0] a, input logic [15:0] idx);
        return a == {14'h0000, idx, 2'b00};
    endfunction

    function automatic logic [31:0] widen(input logic [PINS-1:0] v);
        return {{(32-PINS){1'b0}}, v};
    endfunction

    assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                   paddr: paddr, pwdata: pwdata};

    // Decode; one access per transfer, answered one cycle into the access phase
    wire logic access = req.psel & req.penable & (bus_q == BUS_IDLE);
    wire logic sel_data = hit(req.paddr, `PIN_DATA_IDX);
    wire logic sel_dir = hit(req.paddr, `PIN_DIRECTION_IDX);
    wire logic sel_cfg_lo = hit(req.paddr, `DRIVE_CONFIG_LOW_IDX);
    wire logic sel_cfg_hi = hit(req.paddr, `DRIVE_CONFIG_HIGH_IDX);
    wire logic sel_fn_lo = hit(req.paddr, `FUNCTION_SELECT_LOW_IDX);
    wire logic sel_fn_hi = hit(req.paddr, `FUNCTION_SELECT_HIGH_IDX);
    wire logic mapped = sel_data | sel_dir | sel_cfg_lo | sel_cfg_hi |
                        sel_fn_lo | sel_fn_hi;
    wire logic wr = access & req.pwrite;
    wire logic [PINS-1:0] wbits = req.pwdata[PINS-1:0];

    // Data read mixes stored bits for outputs and pin levels for inputs
    wire logic [PINS-1:0] data_view = (dir_q & pin_in) |
                                      (~dir_q & data_q);
    wire logic [31:0] rd_mux =
        sel_data ? widen(data_view) :
        sel_dir ? widen(dir_q) :
        sel_cfg_lo ? widen(cfg_lo_q) :
        sel_cfg_hi ? widen(cfg_hi_q) :
        sel_fn_lo ? widen(func_lo_q) :
        sel_fn_hi ? widen(func_hi_q) : 32'h0000_0000;

    // Bus state: a done cycle lets penable fall before the next access
    always_comb
    begin
        case (bus_q)
            BUS_IDLE: bus_d = access ? BUS_DONE : BUS_IDLE;
            BUS_DONE: bus_d = BUS_IDLE;
            default: bus_d = BUS_IDLE;
        endcase
    end

    // ============================================================
    // Bus answer flops
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            bus_q <= BUS_IDLE;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            bus_q <= bus_d;
            pready_q <= access;
            pslverr_q <= access & !mapped;
            prdata_q <= (access & !req.pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // ============================================================
    // Configuration registers; reset leaves floating port outputs
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            data_q <= PINS'(`REG_RESET);
            dir_q <= PINS'(`REG_RESET);
            cfg_lo_q <= PINS'(`REG_RESET);
            cfg_hi_q <= PINS'(`REG_RESET);
            func_lo_q <= PINS'(`REG_RESET);
            func_hi_q <= PINS'(`REG_RESET);
        end
        else if (clk_en)
        begin
            if (wr & sel_data)
                data_q <= wbits;
            if (wr & sel_dir)
                dir_q <= wbits;
            if (wr & sel_cfg_lo)
                cfg_lo_q <= wbits;
            if (wr & sel_cfg_hi)
                cfg_hi_q <= wbits;
            if (wr & sel_fn_lo)
                func_lo_q <= wbits;
            if (wr & sel_fn_hi)
                func_hi_q <= wbits;
        end
    end

    // ============================================================
    // Pin drive resolution
    pin_driver #(
        .PINS(PINS)
    ) u_pin_driver (
        .dir(dir_q),
        .data(data_q),
        .cfg_lo(cfg_lo_q),
        .cfg_hi(cfg_hi_q),
        .func_lo(func_lo_q),
        .func_hi(func_hi_q),
        .pwm_out_a(pwm_out_a),
        .pwm_out_b(pwm_out_b),
        .uart_a_tx(uart_a_tx),
        .uart_b_tx(uart_b_tx),
        .serial_clock_out(serial_clock_out),
        .serial_clock_oe(serial_clock_oe),
        .serial_data_out(serial_data_out),
        .drive(drive)
    );

    // Input routing to peripherals, gated by the function select
    wire logic [1:0] fn2 = {func_hi_q[2], func_lo_q[2]};
    wire logic [1:0] fn3 = {func_hi_q[3], func_lo_q[3]};
    wire logic rx_sel = (fn2 == `FUNC_SECONDARY);
    wire logic sin_sel = (fn2 == `FUNC_TERTIARY);
    wire logic sck_sel = (fn3 == `FUNC_TERTIARY);

    // ============================================================
    // Registered pad outputs; one cycle of latency keeps outputs glitch free
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            pin_out_q <= '0;
            pin_oe_n_q <= '1; // Floating after reset
            pull_up_q <= '0;
            pull_down_q <= '0;
            uart_b_rx_q <= 1'b1; // Idle line level
            serial_data_in_q <= 1'b0;
            serial_clock_in_q <= 1'b0;
        end
        else if (clk_en)
        begin
            pin_out_q <= drive.out;
            pin_oe_n_q <= drive.oe_n;
            pull_up_q <= drive.pull_up;
            pull_down_q <= drive.pull_down;
            uart_b_rx_q <= rx_sel ? pin_in[2] : 1'b1;
            serial_data_in_q <= sin_sel ? pin_in[2] : 1'b0;
            serial_clock_in_q <= sck_sel ? pin_in[3] : 1'b0;
        end
    end

    // ============================================================
    // Output assignments
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pin_out = pin_out_q;
    assign pin_oe_n = pin_oe_n_q;
    assign pin_pull_up = pull_up_q;
    assign pin_pull_down = pull_down_q;
    assign uart_b_rx = uart_b_rx_q;
    assign serial_data_in = serial_data_in_q;
    assign serial_clock_in = serial_clock_in_q;

endmodule

// ==== testbench/gpio_port_props.sv ====
// Port-level assertions for the five-pin port
`timescale 1ns/100ps
`include "gpio_port_defines.svh"
module gpio_port_props
#(
    parameter int PINS = `PIN_COUNT
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pads
    input wire logic [PINS-1:0] pin_out,
    input wire logic [PINS-1:0] pin_oe_n,
    input wire logic [PINS-1:0] pin_pull_up,
    input wire logic [PINS-1:0] pin_pull_down,
    input wire logic uart_b_rx
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ============================================================
    // Bus answer: one pulse, one cycle into the access phase
    ready_time_a: assert property (psel && $rose(penable) |=> pready)
        else $error("answer not one cycle after access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("answer held too long");
    ready_cause_a: assert property (pready |-> $past(psel) && $past(penable))
        else $error("answer without request");
    wr_zero_a: assert property (pready && pwrite |-> prdata == '0)
        else $error("write answer carries data");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error outside answer");
    // Bits above the pins never read as one
    high_zero_a: assert property (pready |-> prdata[31:PINS] == '0)
        else $error("upper read bits set");
    // ============================================================
    // Pads: a pulled pin is an input, so it is never driven
    pull_float_a: assert property (((pin_pull_up | pin_pull_down) & ~pin_oe_n) == '0)
        else $error("pulled pin is driven");
    pull_excl_a: assert property ((pin_pull_up & pin_pull_down) == '0)
        else $error("both pulls on");
    // Reset state: pads floating and low, no answer, receive line idle
    rst_state_a: assert property (disable iff (1'b0)
        !rst_n |=> pin_oe_n == '1 && pin_out == '0 && !pready && uart_b_rx)
        else $error("reset state wrong");
endmodule

bind gpio_port gpio_port_props #(.PINS(PINS)) props_i (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_pull_up(pin_pull_up),
    .pin_pull_down(pin_pull_down), .uart_b_rx(uart_b_rx)
);

// ==== testbench/board_pads.sv ====
// Board-side model of the five pads
`timescale 1ns/100ps
module board_pads
#(
    parameter int PINS = 5
)
(
    // Clock
    input wire logic core_clk,
    // Device drive
    input wire logic [PINS-1:0] pin_out,
    input wire logic [PINS-1:0] pin_oe_n,
    input wire logic [PINS-1:0] pin_pull_up,
    input wire logic [PINS-1:0] pin_pull_down,
    // Board drive and resolved level
    input wire logic [PINS-1:0] ext_val,
    input wire logic [PINS-1:0] ext_en,
    output logic [PINS-1:0] pin_level
);
    logic [PINS-1:0] flt_q = '0;
    // Undriven pads wander so no stale level can be trusted
    always @(posedge core_clk)
        flt_q <= ~flt_q;
    // Device drive wins, then the board, then the pulls
    always_comb
        for (int i = 0; i < PINS; i++)
            pin_level[i] = !pin_oe_n[i] ? pin_out[i] :
                ext_en[i] ? ext_val[i] :
                pin_pull_up[i] ? 1'b1 :
                pin_pull_down[i] ? 1'b0 : flt_q[i];
endmodule

// ==== testbench/five_bit_gpio_port_tb_top.sv ====
// Self-checking bench for the five-pin port
`timescale 1ns/100ps
`include "gpio_port_defines.svh"
module five_bit_gpio_port_tb_top;
    logic core_clk = 0;
    logic rst_n = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [31:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, w;
    logic pready, pslverr, uart_b_rx, sdi, sci;
    logic [4:0] pin_in, pin_out, pin_oe_n, pu, pd, e;
    logic [4:0] ext_val = '0;
    logic [4:0] ext_en = '0;
    logic [6:0] per = '0;
    logic [32:0] q[$];
    logic [31:0] seed = 32'h8;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    gpio_port #(.PINS(5)) DUT (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pull_up(pu), .pin_pull_down(pd),
        .pwm_out_a(per[0]), .pwm_out_b(per[1]), .uart_a_tx(per[2]),
        .uart_b_tx(per[3]), .serial_clock_out(per[4]),
        .serial_clock_oe(per[5]), .serial_data_out(per[6]),
        .uart_b_rx(uart_b_rx), .serial_data_in(sdi),
        .serial_clock_in(sci)
    );
    board_pads #(.PINS(5)) board (
        .core_clk(core_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pull_up(pu), .pin_pull_down(pd), .ext_val(ext_val),
        .ext_en(ext_en), .pin_level(pin_in)
    );

    // ============================================================
    // Clock, hang limit and verdict
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            close_out();
        end
    end
    task close_out;
        if (num_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task chk(input logic [32:0] seen, input logic [32:0] want);
        tests_run++;
        if (seen !== want)
        begin
            num_errors++;
            $display("CHECK FAILED %0t saw %h want %h", $time, seen, want);
        end
    endtask
    // One APB transfer; the answer is noted for the watcher
    task automatic rw(input logic wr, input logic [15:0] idx,
                      input logic [31:0] d, input logic [32:0] x);
        q.push_back(x);
        psel <= 1;
        pwrite <= wr;
        paddr <= {14'h0, idx, 2'b00};
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        // Only the bench timeout ends a wait for the answer
        do
            @(posedge core_clk);
        while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
        @(posedge core_clk);
    endtask
    // Answer watcher: a read value with its error flag
    always @(posedge core_clk)
        if (pready === 1'b1)
            chk({pslverr, prdata}, q.size() ? q.pop_front() : 'x);

    // ============================================================
    // Main sequence
    initial
    begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1;
        @(posedge core_clk);
        for (int i = 0; i < 6; i++)
            rw(0, `PIN_DATA_IDX + 16'(i), 0, 0);
        chk(pin_oe_n, 5'h1f);
        // Control registers keep only the pin bits
        for (int i = 1; i < 6; i++)
        begin
            w = rnd();
            rw(1, `PIN_DATA_IDX + 16'(i), w, 0);
            rw(0, `PIN_DATA_IDX + 16'(i), 0, {28'h0, w[4:0]});
        end
        rw(1, `PIN_DIRECTION_IDX, 0, 0);
        rw(1, `FUNCTION_SELECT_LOW_IDX, 0, 0);
        rw(1, `FUNCTION_SELECT_HIGH_IDX, 0, 0);
        rw(1, 16'hf274, rnd(), {1'b1, 32'h0});
        rw(0, 16'hf274, 0, {1'b1, 32'h0});
        // Every output drive code over random data
        for (int c = 0; c < 4; c++)
        begin
            w = rnd();
            rw(1, `PIN_DATA_IDX, w, 0);
            rw(0, `PIN_DATA_IDX, 0, {28'h0, w[4:0]});
            rw(1, `DRIVE_CONFIG_LOW_IDX, {27'h0, {5{c[0]}}}, 0);
            rw(1, `DRIVE_CONFIG_HIGH_IDX, {27'h0, {5{c[1]}}}, 0);
            repeat (2) @(posedge core_clk);
            e = c == 3 ? 5'h0 : c == 1 ? ~w[4:0] : c == 2 ? w[4:0] : 5'h1f;
            chk(pin_oe_n, e);
            chk(pin_out | e, w[4:0] | e);
        end
        // Input mode: pulls per code, pad levels read back
        rw(1, `PIN_DIRECTION_IDX, 32'h1f, 0);
        ext_en <= 5'h1f;
        for (int c = 0; c < 4; c++)
        begin
            w = rnd();
            ext_val <= w[4:0];
            rw(1, `DRIVE_CONFIG_LOW_IDX, {27'h0, {5{c[0]}}}, 0);
            rw(1, `DRIVE_CONFIG_HIGH_IDX, {27'h0, {5{c[1]}}}, 0);
            repeat (2) @(posedge core_clk);
            chk(pu, c == 2 ? 5'h1f : 5'h0);
            chk(pd, c == 1 ? 5'h1f : 5'h0);
            chk(pin_oe_n, 5'h1f);
            rw(0, `PIN_DATA_IDX, 0, {28'h0, w[4:0]});
        end
        // Peripherals on every pin, push-pull drive
        rw(1, `PIN_DIRECTION_IDX, 0, 0);
        rw(1, `FUNCTION_SELECT_LOW_IDX, 32'h0c, 0);
        rw(1, `FUNCTION_SELECT_HIGH_IDX, 32'h1b, 0);
        for (int k = 0; k < 3; k++)
        begin
            w = rnd();
            per <= w[6:0];
            ext_val <= w[11:7];
            repeat (3) @(posedge core_clk);
            chk(pin_oe_n, 5'h04);
            chk(pin_out & 5'h1b, {w[6], w[2], 1'b0, w[1], w[0]});
            chk(uart_b_rx, w[9]);
        end
        // Serial data in on pin 2, serial clock turning round on pin 3
        rw(1, `FUNCTION_SELECT_LOW_IDX, 0, 0);
        rw(1, `FUNCTION_SELECT_HIGH_IDX, 32'h1f, 0);
        for (int k = 0; k < 3; k++)
        begin
            w = rnd();
            per <= w[6:0];
            ext_val <= w[11:7];
            repeat (3) @(posedge core_clk);
            chk(pin_oe_n[3], !w[5]);
            chk(sdi, w[9]);
            chk(sci, w[5] ? w[4] : w[10]);
        end
        // Unassigned code on pin 0 ignores its data
        rw(1, `PIN_DATA_IDX, 32'h1f, 0);
        rw(1, `FUNCTION_SELECT_LOW_IDX, 32'h0d, 0);
        repeat (2) @(posedge core_clk);
        chk({pin_oe_n[0], pin_out[0]}, 2'b00);
        rw(1, `DRIVE_CONFIG_HIGH_IDX, 0, 0);
        repeat (2) @(posedge core_clk);
        chk(pin_oe_n[0], 1'b1);
        close_out();
    end
endmodule
